//--- idfi_bus_if.sv
`default_nettype none

// Request and answer bus between the host end and the board end.
interface idfi_bus_if;
  logic req;
  logic cfg;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic miss;
  logic [31:0] rdata;

  modport dev (
    input req, cfg, we, addr, wdata,
    output ack, miss, rdata
  );

  modport hst (
    output req, cfg, we, addr, wdata,
    input ack, miss, rdata
  );
endinterface

`default_nettype wire

//--- idfi_checker_sva.sv
`default_nettype none

module idfi_checker_sva import idfi_pkg::*; (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic req, // Request valid.
  input wire logic cfg, // Configuration cycle.
  input wire logic we, // Write cycle.
  input wire logic [31:0] addr, // Request address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic ack, // Answer pulse.
  input wire logic miss, // No window claimed the cycle.
  input wire logic [31:0] rdata // Read data.
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // A request taken by the board, then its single-cycle answer.
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Every transfer completes in one access with no extra handshake steps.
  a_answer_next: assert property (s_taken |=> s_answer)
    else $error("Bus answer missing or longer than one cycle.");
  a_req_held: assert property (s_taken |=> req && $stable(addr) && $stable(we))
    else $error("Request changed before its answer.");
  a_ack_caused: assert property (ack |-> $past(req))
    else $error("Answer without a request.");
  a_miss_data: assert property (miss |-> ack && rdata == IDFI_MISS_DATA)
    else $error("Unclaimed cycle returned wrong data.");
  a_cfg_claimed: assert property (ack && $past(cfg) |-> !miss)
    else $error("Configuration cycle went unclaimed.");
  a_id_word: assert property (ack && $past(cfg && !we && addr[7:0] == IDFI_CFG_ID)
    |-> rdata == {IDFI_DEVICE_ID, IDFI_VENDOR_ID})
    else $error("Identifier word wrong.");
  a_init_value: assert property (req && !cfg && we && addr[11:0] == IDFI_BRG_INIT
    |-> wdata == IDFI_BRG_INIT_VAL)
    else $error("Bridge init word wrong.");
  a_window_value: assert property (req && !cfg && we && addr[11:0] == IDFI_BRG_WINDOW
    |-> wdata[7:0] == IDFI_WIN_EN[7:0])
    else $error("Window value low byte wrong.");
  a_mem_enable: assert property (req && cfg && we && addr[7:0] == IDFI_CFG_CMD
    |-> wdata[IDFI_CMD_MEM_BIT])
    else $error("Command write lacks memory enable.");
endmodule

`default_nettype wire

//--- idfi_device_end.sv
`default_nettype none

module idfi_device_end import idfi_pkg::*; #(
  parameter logic [15:0] DEVICE_ID = IDFI_DEVICE_ID // Arbitrary variant code.
) (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  idfi_bus_if.dev bus, // Host-facing bus.
  input wire logic [IDFI_LINES-1:0] line_in, // Input levels, 1 above 2 V.
  output logic [IDFI_LINES-1:0] relay_out, // Output port latches, 1 opens.
  output logic window_on // Register window is forwarded.
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // True when an address falls in the 4 KB window at base.
  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base);
    win_hit = (a[31:IDFI_WIN_BITS] == base[31:IDFI_WIN_BITS]);
  endfunction

  // True when an offset addresses byte register p of a three-port bank.
  function automatic logic bank_hit(input logic [11:0] off, input logic [11:0] base,
                                    input int p);
    bank_hit = (off == base + 12'(p));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [15:0] cmd_reg, cmd_next;
  logic [31:0] bar0_reg, bar0_next;
  logic [31:0] bar1_reg, bar1_next;
  logic [31:0] win_reg, win_next;
  logic [31:0] init_reg, init_next;
  logic [7:0] out_reg [IDFI_PORTS];
  logic [7:0] out_next [IDFI_PORTS];
  logic [23:0] fi_reg, fi_next;
  logic [23:0] fe_reg, fe_next;
  logic clr_f_reg, clr_f_next;
  logic clr_i_reg, clr_i_next;
  logic ack_reg, ack_next;
  logic miss_reg, miss_next;
  logic [31:0] rdata_reg, rdata_next;

  logic take, mem_en, bar0_hit, bar1_hit;
  logic [11:0] off;
  logic [IDFI_LINES-1:0] filt_val;

  ////////////////////////////////////////////////////////////////////////////
  // Input filtering shared by all input ports.
  idfi_glitch_filter #(
    .LINES(IDFI_LINES),
    .IW(IDFI_FI_WIDTH)
  ) u_filter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .raw_in(line_in),
    .filt_en(fe_reg),
    .interval(fi_reg[IDFI_FI_WIDTH-1:0]),
    .clr_filter(clr_f_reg),
    .clr_interval(clr_i_reg),
    .value(filt_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: a request is taken whenever no answer is pending.
  always_comb begin
    take = bus.req && !ack_reg;
    mem_en = cmd_reg[IDFI_CMD_MEM_BIT];
    off = bus.addr[IDFI_WIN_BITS-1:0];
    bar0_hit = take && !bus.cfg && mem_en && win_hit(bus.addr, bar0_reg);
    bar1_hit = take && !bus.cfg && mem_en && !bar0_hit &&
               win_reg[IDFI_WIN_EN_BIT] && win_hit(bus.addr, win_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file: next values and read data for the taken request.
  always_comb begin
    cmd_next = cmd_reg;
    bar0_next = bar0_reg;
    bar1_next = bar1_reg;
    win_next = win_reg;
    init_next = init_reg;
    out_next = out_reg;
    fi_next = fi_reg;
    fe_next = fe_reg;
    clr_f_next = 1'b0;
    clr_i_next = 1'b0;
    ack_next = take;
    miss_next = take && !bus.cfg && !bar0_hit && !bar1_hit;
    rdata_next = rdata_reg;

    // Configuration header.
    if (take && bus.cfg) begin
      case (bus.addr[7:0])
        IDFI_CFG_ID: begin
          rdata_next = {DEVICE_ID, IDFI_VENDOR_ID};
        end
        IDFI_CFG_CMD: begin
          rdata_next = {16'h0000, cmd_reg};
          if (bus.we) begin
            cmd_next = bus.wdata[15:0];
          end
        end
        IDFI_CFG_BAR0: begin
          rdata_next = bar0_reg;
          if (bus.we) begin
            bar0_next = {bus.wdata[31:IDFI_WIN_BITS], 12'h000};
          end
        end
        IDFI_CFG_BAR1: begin
          rdata_next = bar1_reg;
          if (bus.we) begin
            bar1_next = {bus.wdata[31:IDFI_WIN_BITS], 12'h000};
          end
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end

    // Bridge window.
    if (bar0_hit) begin
      case (off)
        IDFI_BRG_WINDOW: begin
          rdata_next = win_reg;
          if (bus.we) begin
            win_next = bus.wdata;
          end
        end
        IDFI_BRG_INIT: begin
          rdata_next = init_reg;
          if (bus.we) begin
            init_next = bus.wdata;
          end
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end

    // Device window: byte registers in the low lane, one access per transfer.
    if (bar1_hit) begin
      rdata_next = 32'h00000000;
      for (int p = 0; p < IDFI_PORTS; p++) begin
        if (bank_hit(off, IDFI_PORT_IN0, p)) begin
          rdata_next = {24'h000000, filt_val[p*8 +: 8]};
        end
        if (bank_hit(off, IDFI_PORT_OUT0, p)) begin
          rdata_next = {24'h000000, out_reg[p]};
          if (bus.we) begin
            out_next[p] = bus.wdata[7:0];
          end
        end
        if (bank_hit(off, IDFI_FI0, p)) begin
          rdata_next = {24'h000000, fi_reg[p*8 +: 8]};
          if (bus.we) begin
            fi_next[p*8 +: 8] = bus.wdata[7:0];
          end
        end
        if (bank_hit(off, IDFI_FE0, p)) begin
          rdata_next = {24'h000000, fe_reg[p*8 +: 8]};
          if (bus.we) begin
            fe_next[p*8 +: 8] = bus.wdata[7:0];
          end
        end
      end
      if (off == IDFI_ID_REG) begin
        rdata_next = {24'h000000, IDFI_BOARD_ID};
      end
      if (off == IDFI_CLEAR && bus.we) begin
        clr_f_next = bus.wdata[IDFI_CLR_FILTER_BIT];
        clr_i_next = bus.wdata[IDFI_CLR_INTERVAL_BIT];
      end
    end

    // Reserved interval bits above bit 19 always read as zero.
    fi_next[23:IDFI_FI_WIDTH] = '0;

    // Unclaimed memory cycles answer with all ones.
    if (miss_next) begin
      rdata_next = IDFI_MISS_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file flip-flops.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= IDFI_CMD_RESET;
      bar0_reg <= IDFI_BAR_RESET;
      bar1_reg <= IDFI_BAR_RESET;
      win_reg <= IDFI_WIN_RESET;
      init_reg <= IDFI_WIN_RESET;
      for (int p = 0; p < IDFI_PORTS; p++) begin
        out_reg[p] <= IDFI_OUT_RESET;
      end
      fi_reg <= IDFI_FI_RESET;
      fe_reg <= {IDFI_PORTS{IDFI_FE_RESET}};
      clr_f_reg <= 1'b0;
      clr_i_reg <= 1'b0;
      ack_reg <= 1'b0;
      miss_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      cmd_reg <= cmd_next;
      bar0_reg <= bar0_next;
      bar1_reg <= bar1_next;
      win_reg <= win_next;
      init_reg <= init_next;
      out_reg <= out_next;
      fi_reg <= fi_next;
      fe_reg <= fe_next;
      clr_f_reg <= clr_f_next;
      clr_i_reg <= clr_i_next;
      ack_reg <= ack_next;
      miss_reg <= miss_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Answer group, all from flip-flops.
  assign bus.ack = ack_reg;
  assign bus.miss = miss_reg;
  assign bus.rdata = rdata_reg;

  // Output port latches drive the relays.
  for (genvar p = 0; p < IDFI_PORTS; p++) begin : g_out
    assign relay_out[p*8 +: 8] = out_reg[p];
  end

  // Window status for the board's own view.
  assign window_on = cmd_reg[IDFI_CMD_MEM_BIT] && win_reg[IDFI_WIN_EN_BIT];

endmodule

`default_nettype wire

//--- idfi_glitch_filter.sv
`default_nettype none

module idfi_glitch_filter import idfi_pkg::*; #(
  parameter int LINES = IDFI_LINES,
  parameter int IW = IDFI_FI_WIDTH
) (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic [LINES-1:0] raw_in, // Line levels.
  input wire logic [LINES-1:0] filt_en, // Per-line filter enables.
  input wire logic [IW-1:0] interval, // Interval in 200 ns units.
  input wire logic clr_filter, // Filter restart pulse.
  input wire logic clr_interval, // Interval clock restart pulse.
  output logic [LINES-1:0] value // Reported line levels.
);

  localparam int UW = $clog2(IDFI_UNIT_CYCLES + 1);
  localparam logic [UW-1:0] UNIT_LAST = UW'(IDFI_UNIT_CYCLES - 1);

  // Refuse shapes the logic cannot serve.
  if (LINES < 1 || IW < 1) begin : g_bad
    $error("idfi_glitch_filter needs at least one line and one interval bit");
  end

  logic [UW-1:0] unit_reg, unit_next;
  logic [IW-1:0] ivl_reg, ivl_next;
  logic [LINES-1:0] raw_reg, seen_reg, seen_next, stable_reg, stable_next;
  logic [LINES-1:0] value_next, chg;
  logic unit_tick, ivl_done;

  ////////////////////////////////////////////////////////////////////////////
  // Interval clock: a 200 ns prescaler and a shared interval counter.
  always_comb begin
    unit_tick = (unit_reg == UNIT_LAST);
    ivl_done = unit_tick && !clr_interval &&
               (({1'b0, ivl_reg} + (IW+1)'(1)) >= {1'b0, interval});
    if (clr_interval) begin
      unit_next = '0;
      ivl_next = '0;
    end else if (unit_tick) begin
      unit_next = '0;
      ivl_next = ivl_done ? '0 : ivl_reg + IW'(1);
    end else begin
      unit_next = unit_reg + UW'(1);
      ivl_next = ivl_reg;
    end
  end

  assign chg = raw_in ^ raw_reg;

  // Each enabled line qualifies a level only if it did not move for a whole interval.
  for (genvar i = 0; i < LINES; i++) begin : g_line
    assign seen_next[i] = clr_filter ? 1'b1 :
                          (ivl_done ? chg[i] : (seen_reg[i] | chg[i]));
    assign stable_next[i] = !filt_en[i] ? raw_reg[i] :
                            ((ivl_done && !seen_reg[i] && !chg[i] && !clr_filter) ?
                             raw_reg[i] : stable_reg[i]);
    assign value_next[i] = filt_en[i] ? stable_reg[i] : raw_reg[i];
  end

  // Registers of the filter.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      unit_reg <= '0;
      ivl_reg <= '0;
      raw_reg <= '0;
      seen_reg <= '1;
      stable_reg <= '0;
      value <= '0;
    end else begin
      unit_reg <= unit_next;
      ivl_reg <= ivl_next;
      raw_reg <= raw_in;
      seen_reg <= seen_next;
      stable_reg <= stable_next;
      value <= value_next;
    end
  end

endmodule

`default_nettype wire

//--- idfi_host_end.sv
`default_nettype none

module idfi_host_end import idfi_pkg::*; (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  idfi_bus_if.hst bus, // Bus toward the board.
  input wire logic init_start, // Pulse: run the bring-up sequence.
  input wire logic [31:0] bar0_base, // Bridge window base to assign.
  input wire logic [31:0] bar1_base, // Register window base to assign.
  output logic init_done, // Bring-up finished.
  output logic [31:0] id_value, // Identifier word read at bring-up.
  input wire logic usr_valid, // Register access request.
  input wire logic usr_write, // 1 write, 0 read.
  input wire logic [11:0] usr_off, // Byte offset in register window.
  input wire logic [7:0] usr_wdata, // Write byte.
  output logic usr_ready, // Access accepted this cycle.
  output logic usr_done, // Pulse: access finished.
  output logic usr_miss, // Last access was not claimed.
  output logic [7:0] usr_rdata // Read byte of last access.
);

  idfi_hstate_t state_reg, state_next;
  logic req_reg, req_next, cfg_reg, cfg_next, we_reg, we_next;
  logic [31:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic [31:0] b0_reg, b0_next, b1_reg, b1_next, id_reg, id_next;
  logic done_reg, done_next, udone_reg, udone_next, miss_reg, miss_next;
  logic [7:0] rdata_reg, rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: each state other than IDLE issues one request and advances on its answer.
  always_comb begin
    state_next = state_reg;
    b0_next = b0_reg;
    b1_next = b1_reg;
    id_next = id_reg;
    done_next = done_reg;
    udone_next = 1'b0;
    miss_next = miss_reg;
    rdata_next = rdata_reg;
    usr_ready = (state_reg == IDFI_H_IDLE) && done_reg && !init_start;
    case (state_reg)
      IDFI_H_IDLE: begin
        if (init_start) begin
          b0_next = bar0_base;
          b1_next = bar1_base;
          done_next = 1'b0;
          state_next = IDFI_H_ID;
        end else if (usr_valid && usr_ready) begin
          state_next = IDFI_H_USER;
        end
      end
      IDFI_H_ID: begin
        if (bus.ack) begin
          id_next = bus.rdata;
          state_next = IDFI_H_BAR0;
        end
      end
      IDFI_H_BAR0: state_next = bus.ack ? IDFI_H_BAR1 : state_reg;
      IDFI_H_BAR1: state_next = bus.ack ? IDFI_H_CMDR : state_reg;
      IDFI_H_CMDR: state_next = bus.ack ? IDFI_H_CMDW : state_reg;
      IDFI_H_CMDW: state_next = bus.ack ? IDFI_H_INIT : state_reg;
      IDFI_H_INIT: state_next = bus.ack ? IDFI_H_WIN : state_reg;
      IDFI_H_WIN: begin
        if (bus.ack) begin
          done_next = 1'b1;
          state_next = IDFI_H_IDLE;
        end
      end
      IDFI_H_USER: begin
        if (bus.ack) begin
          rdata_next = bus.rdata[7:0];
          miss_next = bus.miss;
          udone_next = 1'b1;
          state_next = IDFI_H_IDLE;
        end
      end
      default: state_next = IDFI_H_IDLE;
    endcase
  end

  // Request fields are loaded once, on entry to each state.
  always_comb begin
    req_next = req_reg;
    cfg_next = cfg_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (state_next != state_reg) begin
      req_next = (state_next != IDFI_H_IDLE);
      cfg_next = 1'b1;
      we_next = 1'b1;
      wdata_next = 32'h00000000;
      case (state_next)
        IDFI_H_ID: begin
          we_next = 1'b0;
          addr_next = {24'h000000, IDFI_CFG_ID};
        end
        IDFI_H_BAR0: begin
          addr_next = {24'h000000, IDFI_CFG_BAR0};
          wdata_next = b0_next;
        end
        IDFI_H_BAR1: begin
          addr_next = {24'h000000, IDFI_CFG_BAR1};
          wdata_next = b1_reg;
        end
        IDFI_H_CMDR: begin
          we_next = 1'b0;
          addr_next = {24'h000000, IDFI_CFG_CMD};
        end
        IDFI_H_CMDW: begin
          addr_next = {24'h000000, IDFI_CFG_CMD};
          wdata_next = {16'h0000, bus.rdata[15:0] | IDFI_CMD_MEM_EN};
        end
        IDFI_H_INIT: begin
          cfg_next = 1'b0;
          addr_next = {b0_reg[31:IDFI_WIN_BITS], IDFI_BRG_INIT};
          wdata_next = IDFI_BRG_INIT_VAL;
        end
        IDFI_H_WIN: begin
          cfg_next = 1'b0;
          addr_next = {b0_reg[31:IDFI_WIN_BITS], IDFI_BRG_WINDOW};
          wdata_next = (b1_reg & IDFI_WIN_MASK) | IDFI_WIN_EN;
        end
        IDFI_H_USER: begin
          cfg_next = 1'b0;
          we_next = usr_write;
          addr_next = {b1_reg[31:IDFI_WIN_BITS], usr_off};
          wdata_next = {24'h000000, usr_wdata};
        end
        default: begin
          req_next = 1'b0;
        end
      endcase
    end
  end

  // Sequencer flip-flops.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IDFI_H_IDLE;
      req_reg <= 1'b0;
      cfg_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      b0_reg <= 32'h00000000;
      b1_reg <= 32'h00000000;
      id_reg <= 32'h00000000;
      done_reg <= 1'b0;
      udone_reg <= 1'b0;
      miss_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      cfg_reg <= cfg_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      b0_reg <= b0_next;
      b1_reg <= b1_next;
      id_reg <= id_next;
      done_reg <= done_next;
      udone_reg <= udone_next;
      miss_reg <= miss_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign bus.req = req_reg;
  assign bus.cfg = cfg_reg;
  assign bus.we = we_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign init_done = done_reg;
  assign id_value = id_reg;
  assign usr_done = udone_reg;
  assign usr_miss = miss_reg;
  assign usr_rdata = rdata_reg;

endmodule

`default_nettype wire

//--- idfi_pkg.sv
// Behaviour
// - Config header shows vendor and device identifiers.
// - Two 4 KB memory windows, bridge then registers.
// - Base registers at config 0x10 and 0x14.
// - Host writes 0x0000AEAE at bridge bridge_init_value.
// - Host writes masked base with bit 7 at 0xC0.
// - Host sets memory enable bit in command register.
// - Fixed port directions, single access, no handshake.
// - Input bit n reads line n level.
// - Filtering disabled on every line after reset.
// - Per-line enables, one shared interval.
// - Interval counts 200 ns units.
// - Interval spread over low, middle, high bytes.
// - Clear 0x03 resets filters, restarts interval timer.
// - Enable byte 0xFF filters all eight lines.
// - Software programs interval, clears, enables, then reads.
// - Filter passes only pulses meeting the interval.
`default_nettype none

package idfi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space offsets, fields and identity.
  localparam logic [7:0] IDFI_CFG_ID = 8'h00;
  localparam logic [7:0] IDFI_CFG_CMD = 8'h04;
  localparam logic [7:0] IDFI_CFG_BAR0 = 8'h10;
  localparam logic [7:0] IDFI_CFG_BAR1 = 8'h14;
  localparam logic [15:0] IDFI_CMD_MEM_EN = 16'h0002;
  localparam int IDFI_CMD_MEM_BIT = 1;
  localparam logic [15:0] IDFI_CMD_RESET = 16'h0000;
  localparam logic [31:0] IDFI_BAR_RESET = 32'h00000000;
  localparam logic [15:0] IDFI_VENDOR_ID = 16'hA5C3; // Arbitrary value.
  localparam logic [15:0] IDFI_DEVICE_ID = 16'h3C01; // Arbitrary value.
  localparam logic [7:0] IDFI_BOARD_ID = 8'h5A; // Arbitrary value.

  ////////////////////////////////////////////////////////////////////////////
  // Bridge window offsets and values; each window spans 4 KB.
  localparam int IDFI_WIN_BITS = 12;
  localparam logic [11:0] IDFI_BRG_WINDOW = 12'h0C0;
  localparam logic [11:0] IDFI_BRG_INIT = 12'h340;
  localparam logic [31:0] IDFI_BRG_INIT_VAL = 32'h0000AEAE;
  localparam logic [31:0] IDFI_WIN_MASK = 32'hFFFFFF00;
  localparam logic [31:0] IDFI_WIN_EN = 32'h00000080;
  localparam int IDFI_WIN_EN_BIT = 7;
  localparam logic [31:0] IDFI_WIN_RESET = 32'h00000000;
  localparam logic [31:0] IDFI_MISS_DATA = 32'hFFFFFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Device register offsets, fields and reset values.
  localparam logic [11:0] IDFI_PORT_IN0 = 12'h000;
  localparam logic [11:0] IDFI_PORT_OUT0 = 12'h003;
  localparam logic [11:0] IDFI_ID_REG = 12'h006;
  localparam logic [11:0] IDFI_CLEAR = 12'h007;
  localparam logic [11:0] IDFI_FI0 = 12'h008;
  localparam logic [11:0] IDFI_FE0 = 12'h00C;
  localparam int IDFI_PORTS = 3;
  localparam int IDFI_LINES = 24;
  localparam int IDFI_CLR_INTERVAL_BIT = 0;
  localparam int IDFI_CLR_FILTER_BIT = 1;
  localparam int IDFI_FI_WIDTH = 20;
  localparam logic [7:0] IDFI_FE_RESET = 8'h00;
  localparam logic [7:0] IDFI_OUT_RESET = 8'hFF;
  localparam logic [23:0] IDFI_FI_RESET = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one interval unit is 200 ns.
  localparam int IDFI_CLK_NS = 10;
  localparam int IDFI_UNIT_NS = 200;
  localparam int IDFI_UNIT_CYCLES = (IDFI_UNIT_NS + IDFI_CLK_NS - 1) / IDFI_CLK_NS;

  // Host sequencer states.
  typedef enum logic [3:0] {
    IDFI_H_IDLE,
    IDFI_H_ID,
    IDFI_H_BAR0,
    IDFI_H_BAR1,
    IDFI_H_CMDR,
    IDFI_H_CMDW,
    IDFI_H_INIT,
    IDFI_H_WIN,
    IDFI_H_USER
  } idfi_hstate_t;

endpackage

`default_nettype wire

//--- isolated_dio_filtered_input_test.sv
`default_nettype none

module isolated_dio_filtered_input_test import idfi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic init_start = 1'b0;
  logic [23:0] line_in = 24'h000000;
  logic usr_valid = 1'b0;
  logic usr_write = 1'b0;
  logic [11:0] usr_off = 12'h000;
  logic [7:0] usr_wdata = 8'h00;
  logic [23:0] relay_out;
  logic window_on, init_done, usr_ready, usr_done, usr_miss;
  logic [31:0] id_value;
  logic [7:0] usr_rdata;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h98CE21AE;
  logic [23:0] v;

  idfi_bus_if bus_if();
  idfi_device_end i_idfi_device_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
    .line_in(line_in), .relay_out(relay_out), .window_on(window_on));
  idfi_host_end i_idfi_host_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
    .init_start(init_start), .bar0_base(32'h000D0000), .bar1_base(32'h000D1000),
    .init_done(init_done), .id_value(id_value), .usr_valid(usr_valid),
    .usr_write(usr_write), .usr_off(usr_off), .usr_wdata(usr_wdata), .usr_ready(usr_ready),
    .usr_done(usr_done), .usr_miss(usr_miss), .usr_rdata(usr_rdata));
  idfi_checker_sva i_idfi_checker_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req(bus_if.req), .cfg(bus_if.cfg), .we(bus_if.we), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .ack(bus_if.ack), .miss(bus_if.miss), .rdata(bus_if.rdata));

  // Clock generation and hang guard.
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  // Picks the byte of one port out of a line vector.
  function automatic logic [7:0] port_byte(input logic [23:0] lines, input int p);
    return lines[8*p +: 8];
  endfunction

  // Compares and counts.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access through the host user port.
  task automatic access(input logic w, input logic [11:0] off, input logic [7:0] d);
    int n;
    n = 0;
    usr_valid = 1'b1;
    usr_write = w;
    usr_off = off;
    usr_wdata = d;
    while (usr_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys) #1;
      n++;
    end
    @(posedge clk_sys) #1;
    usr_valid = 1'b0;
    while (usr_done !== 1'b1 && n < 100) begin
      @(posedge clk_sys) #1;
      n++;
    end
    check({31'h00000000, usr_done}, 32'h00000001);
    @(posedge clk_sys) #1;
  endtask

  // Reads every input port and compares against the given lines.
  task automatic read_ports(input logic [23:0] lines);
    for (int p = 0; p < IDFI_PORTS; p++) begin
      access(1'b0, IDFI_PORT_IN0 + 12'(p), 8'h00);
      check({24'h000000, usr_rdata}, {24'h000000, port_byte(lines, p)});
    end
  endtask

  // Prints the counts and the verdict.
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: bring-up, plain ports, then filtering.
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    @(posedge clk_sys) #1 init_start = 1'b1;
    @(posedge clk_sys) #1 init_start = 1'b0;
    for (int n = 0; n < 200 && init_done !== 1'b1; n++) @(posedge clk_sys) #1;
    check(id_value, {IDFI_DEVICE_ID, IDFI_VENDOR_ID});
    check({31'h00000000, window_on}, 32'h00000001);
    access(1'b0, IDFI_ID_REG, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, IDFI_BOARD_ID});
    for (int i = 0; i < 6; i++) begin
      line_in = 24'($random(seed));
      repeat (4) @(posedge clk_sys) #1;
      read_ports(line_in);
      v = 24'($random(seed));
      access(1'b1, IDFI_PORT_OUT0 + 12'(i % 3), port_byte(v, 0));
      check({24'h000000, relay_out[8*(i%3) +: 8]}, {24'h000000, port_byte(v, 0)});
    end
    access(1'b1, IDFI_FI0, 8'h02);
    access(1'b1, IDFI_FI0 + 12'h001, 8'h00);
    access(1'b1, IDFI_FI0 + 12'h002, 8'hF0);
    access(1'b0, IDFI_FI0 + 12'h002, 8'h00);
    check({24'h000000, usr_rdata}, 32'h00000000);
    access(1'b0, IDFI_FI0, 8'h00);
    check({24'h000000, usr_rdata}, 32'h00000002);
    access(1'b1, IDFI_CLEAR, 8'h03);
    access(1'b1, IDFI_FE0, 8'hFF);
    access(1'b0, IDFI_FE0, 8'h00);
    check({24'h000000, usr_rdata}, 32'h000000FF);
    v = line_in;
    line_in = v ^ 24'h00FFFF;
    repeat (3) @(posedge clk_sys) #1;
    access(1'b0, IDFI_PORT_IN0 + 12'h001, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, port_byte(line_in, 1)});
    line_in = v;
    repeat (3) @(posedge clk_sys) #1;
    access(1'b0, IDFI_PORT_IN0, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, port_byte(v, 0)});
    line_in = v ^ 24'h0000FF;
    access(1'b0, IDFI_PORT_IN0, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, port_byte(v, 0)});
    repeat (28) @(posedge clk_sys) #1;
    access(1'b0, IDFI_PORT_IN0, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, port_byte(v, 0)});
    repeat (100) @(posedge clk_sys) #1;
    access(1'b0, IDFI_PORT_IN0, 8'h00);
    check({24'h000000, usr_rdata}, {24'h000000, port_byte(line_in, 0)});
    check({31'h00000000, usr_miss}, 32'h00000000);
    // A second reset in mid-run must bring back the power-up state.
    sys_rst = 1'b1;
    @(posedge clk_sys) #1 sys_rst = 1'b0;
    check({8'h00, relay_out}, 32'h00FFFFFF);
    check({31'h00000000, window_on}, 32'h00000000);
    init_start = 1'b1;
    @(posedge clk_sys) #1 init_start = 1'b0;
    for (int n = 0; n < 200 && init_done !== 1'b1; n++) @(posedge clk_sys) #1;
    access(1'b0, IDFI_FE0, 8'h00);
    check({24'h000000, usr_rdata}, 32'h00000000);
    complete_run();
  end
endmodule

`default_nettype wire
